// >>> hdl/gpkb_top.sv
// parallel ports a..h with keyboard interrupt on port a, axi4-lite register slave
// assumes: pins arrive asynchronous; cpu mask, timer and lcd signals are on clk_i
//
// Overview of operation
// - port a pins six and seven flag a key only on a falling edge
// - pins zero to five: edge select 0 means falling, 1 means rising
// - rising edge selected on a key pin turns its pull-up off
// - a valid edge sets the pin status flag and requests a key interrupt
// - overlay option set: port a address reaches key status, not port data
// - summary flag is the OR of all eight key status flags
// - reset or writing 1 to key clear option wipes all status flags
// - with overlay set, writing 1 to a status bit clears only that flag
// - interrupt out needs enable, summary flag and unmasked cpu together
// - key control: summary bit 7, enable bit 6, resets to zero
// - direction bit 1 makes the pin output, 0 makes it input
// - reset clears all direction registers, every pin but port h starts as input
// - writes load latch, except port a with overlay set; read gives pin if input, latch if output
// - reset leaves data latches a..g alone, clears port h data
// - port c pull-ups follow the pull-up option, off after reset
// - port c pin 0 feeds capture input three; software keeps it input
// - port d drives low only, releases for high; reset makes it input
// - port e control bits 1 and 3 route compare outputs, ignoring direction
// - port e pins 0 and 1 feed capture inputs one and two always
// - port g is input only; a set control bit hands the pin to lcd
// - control bit set selects special function; all controls reset zero
// - only port a pins set as inputs take part in key detection
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "gpkb_defines.svh"

module gpkb_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_b_i,
	input  wire logic [ADDR_W-1:0]         s_axi_awaddr_i,
	input  wire logic                      s_axi_awvalid_i,
	output logic                           s_axi_awready_o,
	input  wire logic [31:0]               s_axi_wdata_i,
	input  wire logic [3:0]                s_axi_wstrb_i,
	input  wire logic                      s_axi_wvalid_i,
	output logic                           s_axi_wready_o,
	output logic [1:0]                     s_axi_bresp_o,
	output logic                           s_axi_bvalid_o,
	input  wire logic                      s_axi_bready_i,
	input  wire logic [ADDR_W-1:0]         s_axi_araddr_i,
	input  wire logic                      s_axi_arvalid_i,
	output logic                           s_axi_arready_o,
	output logic [31:0]                    s_axi_rdata_o,
	output logic [1:0]                     s_axi_rresp_o,
	output logic                           s_axi_rvalid_o,
	input  wire logic                      s_axi_rready_i,
	input  wire gpkb_pkg::gpkb_pins_in_t   pins_i,
	output gpkb_pkg::gpkb_pin_drive_t      port_a_o,
	output gpkb_pkg::gpkb_pin_drive_t      port_b_o,
	output gpkb_pkg::gpkb_pin_drive_t      port_c_o,
	output gpkb_pkg::gpkb_pin_drive_t      port_d_o,
	output gpkb_pkg::gpkb_pin_drive_t      port_e_o,
	output gpkb_pkg::gpkb_pin_drive_t      port_g_o,
	output logic [`GPKB_PORT_H_W-1:0]      port_h_o,
	output logic [7:0]                     pullup_a_o,
	output logic [7:0]                     pullup_b_o,
	output logic [7:0]                     pullup_c_o,
	input  wire logic                      cpu_condition_flags_mask_i,
	output logic                           keyboard_irq_o,
	output logic                           capture_input_three_o,
	output logic [1:0]                     capture_inputs_one_two_o,
	input  wire logic [1:0]                compare_outputs_one_two_i,
	input  wire logic [7:0]                lcd_frontplane_lines_i,
	input  wire logic [`GPKB_PORT_H_W-1:0] port_h_special_i
);

	gpkb_pkg::gpkb_pins_in_t pins_meta;
	gpkb_pkg::gpkb_pins_in_t pins_sync;
	logic [7:0] key_prev;

	logic [7:0] latch_a, latch_b, latch_c, latch_d, latch_e, latch_g;
	logic [`GPKB_PORT_H_W-1:0] latch_h;
	logic [7:0] dir_a, dir_b, dir_c, dir_d, dir_e;
	logic [7:0] ctrl_d, ctrl_e, ctrl_g;
	logic [`GPKB_PORT_H_W-1:0] ctrl_h;
	logic [7:0] keyboard_pin_status;
	logic       keyboard_irq_enable;
	logic [`GPKB_KC_EDGE_W-1:0] key_edge_select;
	logic       keyboard_overlay_option;
	logic       pullup_enable_option;

	logic [7:0] key_edge;
	logic       keyboard_summary_flag;

	logic                  aw_held, w_held;
	logic [ADDR_W-1:0]     aw_addr;
	logic [31:0]           w_data;
	logic [3:0]            w_strb;
	logic                  wr_fire;
	logic [`GPKB_IDX_W-1:0] wr_idx;
	logic                  wr_lane;
	logic [7:0]            wr_byte;
	logic [`GPKB_IDX_W-1:0] rd_idx;

	function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
		input logic [7:0] pin);
		port_read = (dir & latch) | (~dir & pin);
	endfunction

	function automatic logic idx_mapped(input logic [`GPKB_IDX_W-1:0] idx);
		unique case (idx)
			`GPKB_IDX_PORT_A, `GPKB_IDX_PORT_B, `GPKB_IDX_PORT_C, `GPKB_IDX_PORT_D,
			`GPKB_IDX_DIR_A, `GPKB_IDX_DIR_B, `GPKB_IDX_DIR_C, `GPKB_IDX_DIR_D,
			`GPKB_IDX_PORT_E, `GPKB_IDX_DIR_E, `GPKB_IDX_CTRL_E, `GPKB_IDX_PORT_G,
			`GPKB_IDX_CTRL_G, `GPKB_IDX_PORT_H, `GPKB_IDX_CTRL_H, `GPKB_IDX_CTRL_D,
			`GPKB_IDX_KEY_CTRL, `GPKB_IDX_OPTION:
				idx_mapped = 1'b1;
			default:
				idx_mapped = 1'b0;
		endcase
	endfunction

	// pins are asynchronous; the first stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pins_meta <= '0;
			pins_sync <= '0;
		end
		else
		begin
			pins_meta <= pins_i;
			pins_sync <= pins_meta;
		end
	end

	// write channel: address and data taken in either order, one write at a time
	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
	assign wr_idx  = aw_addr[`GPKB_IDX_W+1:2];
	assign wr_lane = wr_fire && w_strb[0] && idx_mapped(wr_idx);
	assign wr_byte = w_data[7:0];

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `GPKB_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_fire)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= idx_mapped(wr_idx) ? `GPKB_RESP_OKAY : `GPKB_RESP_SLVERR;
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	// read channel: one read at a time, data registered at the address handshake
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign rd_idx = s_axi_araddr_i[`GPKB_IDX_W+1:2];

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= '0;
			s_axi_rresp_o  <= `GPKB_RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o  <= idx_mapped(rd_idx) ? `GPKB_RESP_OKAY : `GPKB_RESP_SLVERR;
			unique case (rd_idx)
				`GPKB_IDX_PORT_A:
					s_axi_rdata_o <= {24'h000000, keyboard_overlay_option ? keyboard_pin_status
						: port_read(dir_a, latch_a, pins_sync.a)};
				`GPKB_IDX_PORT_B: s_axi_rdata_o <= {24'h000000,
					port_read(dir_b, latch_b, pins_sync.b)};
				`GPKB_IDX_PORT_C: s_axi_rdata_o <= {24'h000000,
					port_read(dir_c, latch_c, pins_sync.c)};
				// a special-function pin of port d reads zero
				`GPKB_IDX_PORT_D: s_axi_rdata_o <= {24'h000000,
					port_read(dir_d, latch_d, pins_sync.d) & ~ctrl_d};
				`GPKB_IDX_DIR_A:  s_axi_rdata_o <= {24'h000000, dir_a};
				`GPKB_IDX_DIR_B:  s_axi_rdata_o <= {24'h000000, dir_b};
				`GPKB_IDX_DIR_C:  s_axi_rdata_o <= {24'h000000, dir_c};
				`GPKB_IDX_DIR_D:  s_axi_rdata_o <= {24'h000000, dir_d};
				`GPKB_IDX_PORT_E: s_axi_rdata_o <= {24'h000000,
					port_read(dir_e, latch_e, pins_sync.e)};
				`GPKB_IDX_DIR_E:  s_axi_rdata_o <= {24'h000000, dir_e};
				`GPKB_IDX_CTRL_E: s_axi_rdata_o <= {24'h000000, ctrl_e};
				`GPKB_IDX_PORT_G: s_axi_rdata_o <= {24'h000000, pins_sync.g};
				`GPKB_IDX_PORT_H: s_axi_rdata_o <= {30'h00000000, latch_h};
				`GPKB_IDX_CTRL_G: s_axi_rdata_o <= {24'h000000, ctrl_g};
				`GPKB_IDX_CTRL_H: s_axi_rdata_o <= {30'h00000000, ctrl_h};
				`GPKB_IDX_CTRL_D: s_axi_rdata_o <= {24'h000000, ctrl_d};
				`GPKB_IDX_KEY_CTRL:
					s_axi_rdata_o <= {24'h000000, keyboard_summary_flag, keyboard_irq_enable,
						key_edge_select};
				`GPKB_IDX_OPTION:
					s_axi_rdata_o <= {29'h00000000, pullup_enable_option, 1'b0,
						keyboard_overlay_option};
				default: s_axi_rdata_o <= '0;
			endcase
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
			s_axi_rvalid_o <= 1'b0;
	end

	// data latches keep their contents through reset, so no reset branch here
	always_ff @(posedge clk_i)
	begin
		if (wr_lane)
		begin
			unique case (wr_idx)
				`GPKB_IDX_PORT_A:
					if (!keyboard_overlay_option)
						latch_a <= wr_byte;
				`GPKB_IDX_PORT_B: latch_b <= wr_byte;
				`GPKB_IDX_PORT_C: latch_c <= wr_byte;
				`GPKB_IDX_PORT_D: latch_d <= wr_byte;
				`GPKB_IDX_PORT_E: latch_e <= wr_byte;
				`GPKB_IDX_PORT_G: latch_g <= wr_byte;
				default: ;
			endcase
		end
	end

	// direction, control and option state
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			dir_a <= `GPKB_REG_RESET;
			dir_b <= `GPKB_REG_RESET;
			dir_c <= `GPKB_REG_RESET;
			dir_d <= `GPKB_REG_RESET;
			dir_e <= `GPKB_REG_RESET;
			ctrl_d <= `GPKB_REG_RESET;
			ctrl_e <= `GPKB_REG_RESET;
			ctrl_g <= `GPKB_REG_RESET;
			ctrl_h <= '0;
			latch_h <= '0;
			keyboard_irq_enable <= 1'b0;
			key_edge_select <= '0;
			keyboard_overlay_option <= 1'b0;
			pullup_enable_option <= 1'b0;
		end
		else if (wr_lane)
		begin
			unique case (wr_idx)
				`GPKB_IDX_DIR_A:  dir_a <= wr_byte;
				`GPKB_IDX_DIR_B:  dir_b <= wr_byte;
				`GPKB_IDX_DIR_C:  dir_c <= wr_byte;
				`GPKB_IDX_DIR_D:  dir_d <= wr_byte;
				`GPKB_IDX_DIR_E:  dir_e <= wr_byte;
				`GPKB_IDX_CTRL_D: ctrl_d <= wr_byte;
				`GPKB_IDX_CTRL_E: ctrl_e <= wr_byte;
				`GPKB_IDX_CTRL_G: ctrl_g <= wr_byte;
				`GPKB_IDX_CTRL_H: ctrl_h <= wr_byte[`GPKB_PORT_H_W-1:0];
				`GPKB_IDX_PORT_H: latch_h <= wr_byte[`GPKB_PORT_H_W-1:0];
				`GPKB_IDX_KEY_CTRL:
				begin
					keyboard_irq_enable <= wr_byte[`GPKB_KC_ENABLE];
					key_edge_select <= wr_byte[`GPKB_KC_EDGE_W-1:0];
				end
				`GPKB_IDX_OPTION:
				begin
					keyboard_overlay_option <= wr_byte[`GPKB_OPT_OVERLAY];
					pullup_enable_option <= wr_byte[`GPKB_OPT_PULLUP];
				end
				default: ;
			endcase
		end
	end

	// key edges from successive synchronised samples, output pins excluded
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			key_prev <= '0;
		else
			key_prev <= pins_sync.a;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_key
			if (gi < `GPKB_KC_EDGE_W)
			begin : g_sel
				assign key_edge[gi] = !dir_a[gi] && (key_edge_select[gi]
					? (!key_prev[gi] && pins_sync.a[gi])
					: (key_prev[gi] && !pins_sync.a[gi]));
				assign pullup_a_o[gi] = !key_edge_select[gi];
			end
			else
			begin : g_fall
				assign key_edge[gi] = !dir_a[gi] && key_prev[gi] && !pins_sync.a[gi];
				assign pullup_a_o[gi] = 1'b1;
			end
		end
	endgenerate

	// new edges win over any clear in the same cycle
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			keyboard_pin_status <= '0;
		else if (wr_lane && wr_idx == `GPKB_IDX_OPTION && wr_byte[`GPKB_OPT_KCLEAR])
			keyboard_pin_status <= key_edge;
		else if (wr_lane && wr_idx == `GPKB_IDX_PORT_A && keyboard_overlay_option)
			keyboard_pin_status <= (keyboard_pin_status & ~wr_byte) | key_edge;
		else
			keyboard_pin_status <= keyboard_pin_status | key_edge;
	end

	assign keyboard_summary_flag = |keyboard_pin_status;
	assign keyboard_irq_o = keyboard_irq_enable && keyboard_summary_flag
		&& !cpu_condition_flags_mask_i;

	// pin drive; out levels gated by enable so undefined latches never leak
	assign port_a_o.oe    = dir_a;
	assign port_a_o.level = latch_a & dir_a;
	assign port_b_o.oe    = dir_b;
	assign port_b_o.level = latch_b & dir_b;
	assign port_c_o.oe    = dir_c;
	assign port_c_o.level = latch_c & dir_c;
	// open drain: drive low only while output and latch is zero
	assign port_d_o.oe    = dir_d & ~ctrl_d & ~latch_d;
	assign port_d_o.level = 8'h00;
	assign port_g_o.oe    = ctrl_g;
	assign port_g_o.level = lcd_frontplane_lines_i & ctrl_g;
	assign port_h_o       = ctrl_h & port_h_special_i | ~ctrl_h & latch_h;

	always_comb
	begin
		port_e_o.oe    = dir_e;
		port_e_o.level = latch_e & dir_e;
		if (ctrl_e[`GPKB_E_CMP1_BIT])
		begin
			port_e_o.oe[`GPKB_E_CMP1_BIT]    = 1'b1;
			port_e_o.level[`GPKB_E_CMP1_BIT] = compare_outputs_one_two_i[0];
		end
		if (ctrl_e[`GPKB_E_CMP2_BIT])
		begin
			port_e_o.oe[`GPKB_E_CMP2_BIT]    = 1'b1;
			port_e_o.level[`GPKB_E_CMP2_BIT] = compare_outputs_one_two_i[1];
		end
	end

	assign pullup_b_o = 8'hFF;
	assign pullup_c_o = {8{pullup_enable_option}};
	// capture works only while software keeps these pins as inputs
	assign capture_input_three_o    = pins_sync.c[0];
	assign capture_inputs_one_two_o = pins_sync.e[1:0];

endmodule

// >>> hdl/gpkb_defines.svh
// register indices, field positions and reset values of the port block
// assumes: byte address of a register is four times its index
`ifndef GPKB_DEFINES_SVH
`define GPKB_DEFINES_SVH

`define GPKB_IDX_W          6
`define GPKB_IDX_PORT_A     6'h00
`define GPKB_IDX_PORT_B     6'h01
`define GPKB_IDX_PORT_C     6'h02
`define GPKB_IDX_PORT_D     6'h03
`define GPKB_IDX_DIR_A      6'h04
`define GPKB_IDX_DIR_B      6'h05
`define GPKB_IDX_DIR_C      6'h06
`define GPKB_IDX_DIR_D      6'h07
`define GPKB_IDX_PORT_E     6'h0A
`define GPKB_IDX_DIR_E      6'h0B
`define GPKB_IDX_CTRL_E     6'h0C
`define GPKB_IDX_PORT_G     6'h12
`define GPKB_IDX_CTRL_G     6'h13
`define GPKB_IDX_PORT_H     6'h14
`define GPKB_IDX_CTRL_H     6'h15
`define GPKB_IDX_CTRL_D     6'h1A
`define GPKB_IDX_KEY_CTRL   6'h1B
`define GPKB_IDX_OPTION     6'h20

`define GPKB_KC_SUMMARY     7
`define GPKB_KC_ENABLE      6
`define GPKB_KC_EDGE_W      6
`define GPKB_OPT_OVERLAY    0
`define GPKB_OPT_KCLEAR     1
`define GPKB_OPT_PULLUP     2
`define GPKB_E_CMP1_BIT     1
`define GPKB_E_CMP2_BIT     3
`define GPKB_PORT_H_W       2

`define GPKB_REG_RESET      8'h00
`define GPKB_RESP_OKAY      2'h0
`define GPKB_RESP_SLVERR    2'h2

`endif

// >>> hdl/gpkb_pkg.sv
// types shared by the port block and its surroundings
// assumes: eight-bit ports, drive and enable per pin
package gpkb_pkg;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] g;
	} gpkb_pins_in_t;

	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe;
	} gpkb_pin_drive_t;

endpackage

// >>> tb/gpkb_pins_model.sv
// board side of the ports: keys and fixed levels meet the port drivers
// assumes: undriven pins follow the board level; port d has board pull-ups
`timescale 1ns/10ps
module gpkb_pins_model (
	input  wire gpkb_pkg::gpkb_pins_in_t   board_i,
	input  wire gpkb_pkg::gpkb_pin_drive_t drv_a_i,
	input  wire gpkb_pkg::gpkb_pin_drive_t drv_b_i,
	input  wire gpkb_pkg::gpkb_pin_drive_t drv_c_i,
	input  wire gpkb_pkg::gpkb_pin_drive_t drv_d_i,
	input  wire gpkb_pkg::gpkb_pin_drive_t drv_e_i,
	input  wire gpkb_pkg::gpkb_pin_drive_t drv_g_i,
	output gpkb_pkg::gpkb_pins_in_t        pins_o
);
	function automatic logic [7:0] mix(gpkb_pkg::gpkb_pin_drive_t d, logic [7:0] ext);
		return (d.oe & d.level) | (~d.oe & ext);
	endfunction
	assign pins_o.a = mix(drv_a_i, board_i.a);
	assign pins_o.b = mix(drv_b_i, board_i.b);
	assign pins_o.c = mix(drv_c_i, board_i.c);
	// open drain: only a low is driven, the pull-up gives the high
	assign pins_o.d = ~drv_d_i.oe & board_i.d;
	assign pins_o.e = mix(drv_e_i, board_i.e);
	assign pins_o.g = mix(drv_g_i, board_i.g);
endmodule

// >>> tb/gpkb_monitor.sv
// checker on the port block pins, key interrupt gating and bus holds
// assumes: bound into gpkb_top, one clock, async active-low reset
`timescale 1ns/10ps
module gpkb_monitor (
	input wire logic                      clk_i,
	input wire logic                      rst_b_i,
	input wire logic                      s_axi_bvalid_o,
	input wire logic                      s_axi_bready_i,
	input wire logic [1:0]                s_axi_bresp_o,
	input wire logic                      s_axi_rvalid_o,
	input wire logic                      s_axi_rready_i,
	input wire logic [31:0]               s_axi_rdata_o,
	input wire gpkb_pkg::gpkb_pins_in_t   pins_i,
	input wire gpkb_pkg::gpkb_pin_drive_t port_d_o,
	input wire gpkb_pkg::gpkb_pin_drive_t port_g_o,
	input wire logic [7:0]                pullup_a_o,
	input wire logic [7:0]                pullup_c_o,
	input wire logic                      cpu_condition_flags_mask_i,
	input wire logic                      keyboard_irq_o,
	input wire logic                      capture_input_three_o,
	input wire logic [1:0]                capture_inputs_one_two_o,
	input wire logic [7:0]                lcd_frontplane_lines_i
);
	logic [1:0] up_cnt;
	// synchronisers hold reset zeros for two edges after release
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			up_cnt <= 2'h0;
		else if (up_cnt != 2'h3)
			up_cnt <= up_cnt + 2'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_irq_mask_gate: assert property (keyboard_irq_o |-> !cpu_condition_flags_mask_i)
		else $error("key interrupt while cpu masked");
	chk_pullup_key_hi: assert property (pullup_a_o[7:6] == 2'h3)
		else $error("pull-up off on falling-only key pin");
	chk_pullup_c_all: assert property (pullup_c_o == 8'h00 || pullup_c_o == 8'hFF)
		else $error("port c pull-ups not uniform");
	chk_port_d_drain: assert property (port_d_o.level == 8'h00)
		else $error("port d drives high");
	chk_lcd_route: assert property (port_g_o.level == (lcd_frontplane_lines_i & port_g_o.oe))
		else $error("port g level not from lcd");
	chk_capture_three: assert property (up_cnt[1] |-> capture_input_three_o == $past(pins_i.c[0], 2))
		else $error("capture three not two cycles after pin");
	chk_capture_pair: assert property (up_cnt[1] |-> capture_inputs_one_two_o == $past(pins_i.e[1:0], 2))
		else $error("capture one two not two cycles after pins");
	chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped before taken");
	chk_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped before taken");
	cov_irq: cover property (keyboard_irq_o);
	cov_lcd: cover property (port_g_o.oe != 8'h00);
	cov_rstall: cover property (s_axi_rvalid_o && !s_axi_rready_i);
endmodule
bind gpkb_top gpkb_monitor gpkb_monitor_inst (.clk_i, .rst_b_i, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_bresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .pins_i, .port_d_o,
	.port_g_o, .pullup_a_o, .pullup_c_o, .cpu_condition_flags_mask_i, .keyboard_irq_o,
	.capture_input_three_o, .capture_inputs_one_two_o, .lcd_frontplane_lines_i);

// >>> tb/gpkb_top_tb_top.sv
// self-checking bench for gpkb_top over axi4-lite, pins through the board model
// assumes: gpkb_monitor bound separately; 10 MHz clock
`timescale 1ns/10ps
`include "gpkb_defines.svh"
module gpkb_top_tb_top;
	logic                      clk_i = 1'b0;
	logic                      rst_b_i = 1'b0;
	logic [7:0]                awaddr = 8'h00, araddr = 8'h00, lcd = 8'h00;
	logic [31:0]               wdata = 32'h0, got, rdata;
	logic                      awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, mask = 1'b0;
	logic                      arvalid = 1'b0, rready = 1'b0, irq, cap3;
	logic                      awready, wready, bvalid, arready, rvalid;
	logic [1:0]                bresp, rresp, resp, cmp = 2'h0, ph, cap12;
	logic [7:0]                pua, pub, puc;
	gpkb_pkg::gpkb_pins_in_t   board = 48'hFE_FF_FF_FF_FF_FF;
	gpkb_pkg::gpkb_pins_in_t   pins;
	gpkb_pkg::gpkb_pin_drive_t pa, pb, pc, pd, pe, pg;
	int                        mismatches = 0, compares = 0;
	localparam logic [5:0] RST_IDX [11] = '{`GPKB_IDX_DIR_A, `GPKB_IDX_DIR_B, `GPKB_IDX_DIR_C,
		`GPKB_IDX_DIR_D, `GPKB_IDX_DIR_E, `GPKB_IDX_CTRL_D, `GPKB_IDX_CTRL_E, `GPKB_IDX_CTRL_G,
		`GPKB_IDX_CTRL_H, `GPKB_IDX_KEY_CTRL, `GPKB_IDX_PORT_H};
	always #50 clk_i = ~clk_i;
	gpkb_top gpkb_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .pins_i(pins), .port_a_o(pa), .port_b_o(pb), .port_c_o(pc),
		.port_d_o(pd), .port_e_o(pe), .port_g_o(pg), .port_h_o(ph), .pullup_a_o(pua),
		.pullup_b_o(pub), .pullup_c_o(puc), .cpu_condition_flags_mask_i(mask),
		.keyboard_irq_o(irq), .capture_input_three_o(cap3), .capture_inputs_one_two_o(cap12),
		.compare_outputs_one_two_i(cmp), .lcd_frontplane_lines_i(lcd), .port_h_special_i(2'h0));
	gpkb_pins_model gpkb_pins_model_inst (.board_i(board), .drv_a_i(pa), .drv_b_i(pb),
		.drv_c_i(pc), .drv_d_i(pd), .drv_e_i(pe), .drv_g_i(pg), .pins_o(pins));
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge clk_i);
			if (!aw_done && awready === 1'b1)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// bvalid rises one edge after both are taken; stall one more so it must stand
		repeat (2) @(posedge clk_i);
		bready <= 1'b1;
		do @(posedge clk_i); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] idx);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		@(posedge clk_i);
		rready <= 1'b1;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
		rd(idx);
		chk(got, {24'h0, e});
		chk({30'h0, resp}, {30'h0, `GPKB_RESP_OKAY});
	endtask
	task automatic print_verdict;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk_i);
		chk({24'h0, puc}, 32'h0);
		rst_b_i <= 1'b1;
		foreach (RST_IDX[i]) rdchk(RST_IDX[i], `GPKB_REG_RESET);
		$display("test reset done");
		board.b <= 8'h3C;
		wr(`GPKB_IDX_PORT_B, 8'hA5);
		wr(`GPKB_IDX_DIR_B, 8'h0F);
		rdchk(`GPKB_IDX_PORT_B, 8'h35);
		chk({16'h0, pb}, 32'h050F);
		wr(`GPKB_IDX_PORT_H, 8'hFF);
		rdchk(`GPKB_IDX_PORT_H, 8'h03);
		chk({30'h0, ph}, 32'h3);
		$display("test ports done");
		wr(`GPKB_IDX_KEY_CTRL, 8'h41);
		chk({24'h0, pua}, 32'hFE);
		board.a[0] <= 1'b1;
		repeat (6) @(posedge clk_i);
		wr(`GPKB_IDX_OPTION, 8'h01);
		rdchk(`GPKB_IDX_PORT_A, 8'h01);
		rdchk(`GPKB_IDX_KEY_CTRL, 8'hC1);
		chk({31'h0, irq}, 32'h1);
		mask <= 1'b1;
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		mask <= 1'b0;
		board.a[7] <= 1'b0;
		repeat (6) @(posedge clk_i);
		rdchk(`GPKB_IDX_PORT_A, 8'h81);
		wr(`GPKB_IDX_PORT_A, 8'h01);
		rdchk(`GPKB_IDX_PORT_A, 8'h80);
		board.a[7] <= 1'b1;
		repeat (6) @(posedge clk_i);
		rdchk(`GPKB_IDX_PORT_A, 8'h80);
		wr(`GPKB_IDX_OPTION, 8'h03);
		rdchk(`GPKB_IDX_KEY_CTRL, 8'h41);
		board.a[1] <= 1'b0;
		repeat (6) @(posedge clk_i);
		rdchk(`GPKB_IDX_PORT_A, 8'h02);
		wr(`GPKB_IDX_OPTION, 8'h02);
		wr(`GPKB_IDX_PORT_A, 8'h20);
		wr(`GPKB_IDX_DIR_A, 8'h20);
		rdchk(`GPKB_IDX_PORT_A, 8'hFD);
		wr(`GPKB_IDX_PORT_A, 8'h00);
		repeat (6) @(posedge clk_i);
		wr(`GPKB_IDX_OPTION, 8'h01);
		rdchk(`GPKB_IDX_PORT_A, 8'h00);
		$display("test keyboard done");
		wr(`GPKB_IDX_OPTION, 8'h04);
		chk({24'h0, puc}, 32'hFF);
		board.c <= 8'hFE;
		board.e <= 8'hFD;
		cmp <= 2'h2;
		lcd <= 8'h5A;
		wr(`GPKB_IDX_PORT_D, 8'h0F);
		wr(`GPKB_IDX_DIR_D, 8'hFF);
		chk({16'h0, pd}, 32'h00F0);
		rdchk(`GPKB_IDX_PORT_D, 8'h0F);
		wr(`GPKB_IDX_CTRL_E, 8'h0A);
		chk({28'h0, pe.level[3], pe.level[1], pe.oe[3], pe.oe[1]}, 32'hB);
		chk({29'h0, cap3, cap12}, 32'h1);
		wr(`GPKB_IDX_CTRL_G, 8'h0F);
		chk({16'h0, pg}, 32'h0A0F);
		wr(`GPKB_IDX_CTRL_H, 8'h01);
		chk({30'h0, ph}, 32'h2);
		rd(6'h3F);
		chk({got[29:0], resp}, {30'h0, `GPKB_RESP_SLVERR});
		wr(6'h3E, 8'h55);
		chk({30'h0, resp}, {30'h0, `GPKB_RESP_SLVERR});
		$display("test special done");
		// mid-run reset: port h data clears, port b latch survives
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rdchk(`GPKB_IDX_PORT_H, 8'h00);
		wr(`GPKB_IDX_DIR_B, 8'h0F);
		rdchk(`GPKB_IDX_PORT_B, 8'h35);
		$display("test reset keep done");
		print_verdict();
	end
	// about 200 cycles expected; a hang ends the run as a failure
	initial
	begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		print_verdict();
	end
endmodule
